// ### hw/flow_trigger_defines.svh
// Offsets, field positions, reset values and timing figures of the block
`ifndef FLOW_TRIGGER_DEFINES_SVH
`define FLOW_TRIGGER_DEFINES_SVH

// Register byte offsets
`define FLOW_CFG_OFFSET   8'hac
`define FLOW_STAT_OFFSET  8'hc0

// Configuration fields
`define HIGH_LSB          16
`define LOW_LSB           8
`define DUR_LSB           4
`define MULT_BIT          3
`define BRD_BIT           2
`define ADDR_BIT          1
`define ANY_BIT           0
`define CFG_RESET         32'h0000_0000
`define CFG_WMASK         32'h00ff_ffff

// Status fields
`define STAT_JAM_BIT      0
`define STAT_PEND_BIT     1
`define STAT_PAUSED_BIT   2
`define STAT_HIGH_BIT     3

// Threshold unit is 64 bytes
`define FILL_UNIT_SHIFT   6

// Bus answers
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

// Timing, clock period and jam figures in ns, and the first long jam code
`define CLK_PERIOD_NS     5
`define JAM_UNIT_NS       5000
`define JAM_STEP_NS       50000
`define JAM_SLOW_EXTRA_NS 2200
`define JAM_LONG_CODE     4'h4

`endif

// ### hw/flow_trigger_pkg.sv
// Types shared by the flow control trigger
package flow_trigger_pkg;
    typedef enum logic {JAM_IDLE, JAM_ACTIVE} jam_state_t;
    typedef enum logic [1:0] {
        PAUSE_OFF, PAUSE_ASK, PAUSE_ON, PAUSE_RESUME
    } pause_state_t;
endpackage

// ### hw/flow_trigger.sv
// Receive FIFO flow control trigger with AXI4-Lite configuration slave
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "flow_trigger_defines.svh"

// Notes on behaviour
// - Any-frame enable plus high level triggers flow control
// - Full-duplex pausing only with any-frame enable
// - Half-duplex any-frame ignores destination address
// - Half-duplex any-frame jams on valid preamble
// - Full-duplex requests pause immediately at high level
// - Pause request held until next transmit opportunity
// - Any-frame enable overrides the three selections
// - Jam time from code, longer at 10 Mbit
// - Thresholds counted in 64-byte units
// - Half-duplex matching frames jammed for coded time
// - Zero-time pause below low after pause sent
// - Nothing sent while transmitter disabled; a running jam drops one cycle after tx_enable falls
module flow_trigger
    import flow_trigger_pkg::*;
#(
    parameter int ADDR_W           = 8,
    parameter int FIFO_LEVEL_W     = 16,
    parameter int JAM_CNT_W        = 18,
    parameter int JAM_UNIT_CYCLES  =
        (`JAM_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter int JAM_STEP_CYCLES  =
        (`JAM_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter int JAM_EXTRA_CYCLES =
        (`JAM_SLOW_EXTRA_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0]       awaddr,
    input  wire logic                    awvalid,
    output logic                         awready,
    // AXI4-Lite write data
    input  wire logic [31:0]             wdata,
    input  wire logic [3:0]              wstrb,
    input  wire logic                    wvalid,
    output logic                         wready,
    // AXI4-Lite write response
    output logic [1:0]                   bresp,
    output logic                         bvalid,
    input  wire logic                    bready,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0]       araddr,
    input  wire logic                    arvalid,
    output logic                         arready,
    // AXI4-Lite read data
    output logic [31:0]                  rdata,
    output logic [1:0]                   rresp,
    output logic                         rvalid,
    input  wire logic                    rready,
    // Link state from the MAC
    input  wire logic [FIFO_LEVEL_W-1:0] rx_fifo_level,
    input  wire logic                    full_duplex,
    input  wire logic                    link_100,
    input  wire logic                    tx_enable,
    // Receive events from the MAC
    input  wire logic                    rx_preamble,
    input  wire logic                    rx_dest_valid,
    input  wire logic                    rx_dest_multicast,
    input  wire logic                    rx_dest_broadcast,
    input  wire logic                    rx_dest_match,
    // Pause frame handshake with the MAC
    output logic                         pause_req,
    output logic                         pause_zero_time,
    input  wire logic                    pause_sent,
    // Back pressure to the MAC
    output logic                         jam
);
    // Threshold field to byte count
    function automatic logic [FIFO_LEVEL_W-1:0] fill_bytes(
        input logic [7:0] units
    );
        fill_bytes = FIFO_LEVEL_W'(units) << `FILL_UNIT_SHIFT;
    endfunction
    // Jam length in cycles for a code and speed
    function automatic logic [JAM_CNT_W-1:0] jam_cycles(
        input logic [3:0] code,
        input logic       slow
    );
        int n;
        unique case (code)
            4'h0:    n = JAM_UNIT_CYCLES;
            4'h1:    n = 2 * JAM_UNIT_CYCLES;
            4'h2:    n = 3 * JAM_UNIT_CYCLES;
            4'h3:    n = 5 * JAM_UNIT_CYCLES;
            default: n = (int'(code) - 3) * JAM_STEP_CYCLES;
        endcase
        n = slow ? n + JAM_EXTRA_CYCLES : n;
        jam_cycles = JAM_CNT_W'(n);
    endfunction
    // Configuration fields
    logic [31:0]       cfg;          // Flow control configuration
    logic [31:0]       next_cfg;
    logic [7:0]        fill_high_threshold;
    logic [7:0]        fill_low_threshold;
    logic [3:0]        jam_duration_code;
    logic              multicast_flow_select;
    logic              broadcast_flow_select;
    logic              address_match_flow_select;
    logic              any_frame_flow_enable;
    // Write channel holding state
    logic              aw_held;      // Address taken, not yet used
    logic              next_aw_held;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [ADDR_W-1:0] next_aw_addr_q;
    logic              w_held;       // Data taken, not yet used
    logic              next_w_held;
    logic [31:0]       w_data_q;
    logic [31:0]       next_w_data_q;
    logic [3:0]        w_strb_q;
    logic [3:0]        next_w_strb_q;
    logic              next_bvalid;
    logic [1:0]        next_bresp;
    logic              next_rvalid;
    logic [31:0]       next_rdata;
    logic [1:0]        next_rresp;
    // Flow control state
    pause_state_t      pause_state;  // Full-duplex pause sequence
    pause_state_t      next_pause_state;
    jam_state_t        jam_state;    // Half-duplex back pressure
    jam_state_t        next_jam_state;
    logic [JAM_CNT_W-1:0] jam_cnt;   // Cycles of jam left
    logic [JAM_CNT_W-1:0] next_jam_cnt;
    // Level comparisons and frame triggers
    logic              high_hit;     // FIFO at or above high level
    logic              low_miss;     // FIFO below low level
    logic              fd_mode;      // Full-duplex pausing enabled
    logic              hd_trigger;   // Frame that starts a jam
    logic              sel_hit;      // Address selections matched
    // Field split of the configuration
    assign fill_high_threshold       = cfg[`HIGH_LSB +: 8];
    assign fill_low_threshold        = cfg[`LOW_LSB +: 8];
    assign jam_duration_code         = cfg[`DUR_LSB +: 4];
    assign multicast_flow_select     = cfg[`MULT_BIT];
    assign broadcast_flow_select     = cfg[`BRD_BIT];
    assign address_match_flow_select = cfg[`ADDR_BIT];
    assign any_frame_flow_enable     = cfg[`ANY_BIT];
    // Threshold comparisons
    assign high_hit = rx_fifo_level >= fill_bytes(fill_high_threshold);
    assign low_miss = rx_fifo_level < fill_bytes(fill_low_threshold);
    // Full-duplex pausing needs any-frame mode
    assign fd_mode = any_frame_flow_enable & full_duplex;
    // Destination selections, unused in any-frame mode
    assign sel_hit = (multicast_flow_select & rx_dest_multicast)
                   | (broadcast_flow_select & rx_dest_broadcast)
                   | (address_match_flow_select & rx_dest_match);
    // Half-duplex jam trigger, none in full duplex or with tx off
    assign hd_trigger = (full_duplex || !tx_enable || !high_hit) ? 1'b0
                      : any_frame_flow_enable ? rx_preamble
                      : (rx_dest_valid & sel_hit);
    // Bus handshake outputs
    assign awready = !aw_held;
    assign wready  = !w_held;
    assign arready = !rvalid;
    // Pause request withheld while transmitter is off
    assign pause_req = tx_enable
                     & ((pause_state == PAUSE_ASK)
                     | (pause_state == PAUSE_RESUME));
    // Back pressure from the jam state
    assign jam = (jam_state == JAM_ACTIVE);
    // Register write and read next values
    always_comb begin
        next_aw_held   = aw_held;
        next_aw_addr_q = aw_addr_q;
        next_w_held    = w_held;
        next_w_data_q  = w_data_q;
        next_w_strb_q  = w_strb_q;
        next_bvalid    = bvalid & !bready; // Dropped once taken
        next_bresp     = bresp;
        next_cfg       = cfg;
        next_rvalid    = rvalid & !rready; // Dropped once taken
        next_rdata     = rdata;
        next_rresp     = rresp;
        // Capture address and data independently
        if (awvalid && awready) begin
            next_aw_held   = 1'b1;
            next_aw_addr_q = awaddr;
        end
        if (wvalid && wready) begin
            next_w_held   = 1'b1;
            next_w_data_q = wdata;
            next_w_strb_q = wstrb;
        end
        // Commit once both are held and no response waits
        if (aw_held && w_held && !bvalid) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            if (aw_addr_q == ADDR_W'(`FLOW_CFG_OFFSET)) begin
                next_bresp = `RESP_OKAY;
                for (int b = 0; b < 4; b++) begin
                    if (w_strb_q[b]) begin
                        next_cfg[8*b +: 8] = w_data_q[8*b +: 8];
                    end
                end
                next_cfg = next_cfg & `CFG_WMASK;
            end else if (aw_addr_q == ADDR_W'(`FLOW_STAT_OFFSET)) begin
                // Status is read only, write ignored
                next_bresp = `RESP_OKAY;
            end else begin
                // Unmapped address
                next_bresp = `RESP_SLVERR;
            end
        end
        // Read answer one cycle after address
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rresp  = `RESP_OKAY;
            next_rdata  = 32'h0000_0000;
            if (araddr == ADDR_W'(`FLOW_CFG_OFFSET)) begin
                next_rdata = cfg;
            end else if (araddr == ADDR_W'(`FLOW_STAT_OFFSET)) begin
                next_rdata[`STAT_JAM_BIT]    = jam;
                next_rdata[`STAT_PEND_BIT]   = pause_req;
                next_rdata[`STAT_PAUSED_BIT] = (pause_state == PAUSE_ON);
                next_rdata[`STAT_HIGH_BIT]   = high_hit;
            end else begin
                next_rresp = `RESP_SLVERR;
            end
        end
    end
    // Register bus flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held   <= 1'b0;
            aw_addr_q <= '0;
            w_held    <= 1'b0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            bvalid    <= 1'b0;
            bresp     <= `RESP_OKAY;
            cfg       <= `CFG_RESET;
            rvalid    <= 1'b0;
            rdata     <= 32'h0000_0000;
            rresp     <= `RESP_OKAY;
        end else begin
            aw_held   <= next_aw_held;
            aw_addr_q <= next_aw_addr_q;
            w_held    <= next_w_held;
            w_data_q  <= next_w_data_q;
            w_strb_q  <= next_w_strb_q;
            bvalid    <= next_bvalid;
            bresp     <= next_bresp;
            cfg       <= next_cfg;
            rvalid    <= next_rvalid;
            rdata     <= next_rdata;
            rresp     <= next_rresp;
        end
    end
    // Full-duplex pause sequence next state
    always_comb begin
        next_pause_state = pause_state;
        if (!fd_mode) begin
            // Leaving the mode drops any pending pause
            next_pause_state = PAUSE_OFF;
        end else begin
            unique case (pause_state)
                PAUSE_OFF: begin
                    if (high_hit) begin
                        next_pause_state = PAUSE_ASK;
                    end
                end
                PAUSE_ASK: begin
                    if (pause_req && pause_sent) begin
                        next_pause_state = PAUSE_ON;
                    end
                end
                PAUSE_ON: begin
                    if (low_miss) begin
                        next_pause_state = PAUSE_RESUME;
                    end
                end
                PAUSE_RESUME: begin
                    if (pause_req && pause_sent) begin
                        next_pause_state = PAUSE_OFF;
                    end
                end
            endcase
        end
    end
    // Pause state and zero-time flag flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pause_state     <= PAUSE_OFF;
            pause_zero_time <= 1'b0;
        end else begin
            pause_state     <= next_pause_state;
            pause_zero_time <= (next_pause_state == PAUSE_RESUME);
        end
    end
    // Half-duplex jam timer next state
    always_comb begin
        next_jam_state = jam_state;
        next_jam_cnt   = jam_cnt;
        unique case (jam_state)
            JAM_IDLE: begin
                if (hd_trigger) begin
                    // Speed sampled here holds for the jam
                    next_jam_state = JAM_ACTIVE;
                    next_jam_cnt   = jam_cycles(jam_duration_code,
                                                !link_100);
                end
            end
            JAM_ACTIVE: begin
                if (!tx_enable || full_duplex) begin
                    next_jam_state = JAM_IDLE;
                    next_jam_cnt   = '0;
                end else if (jam_cnt <= JAM_CNT_W'(1)) begin
                    next_jam_state = JAM_IDLE;
                    next_jam_cnt   = '0;
                end else begin
                    next_jam_cnt = jam_cnt - JAM_CNT_W'(1);
                end
            end
        endcase
    end

    // Jam timer flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            jam_state <= JAM_IDLE;
            jam_cnt   <= '0;
        end else begin
            jam_state <= next_jam_state;
            jam_cnt   <= next_jam_cnt;
        end
    end

endmodule

// ### tb/flow_trigger_checker.sv
// Port-level assertions for the flow control trigger
`timescale 1ns/1ps
module flow_trigger_checker #(
    parameter int JAM_UNIT_CYCLES  = 1000,
    parameter int JAM_STEP_CYCLES  = 10000,
    parameter int JAM_EXTRA_CYCLES = 440
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Link state and receive events
    input wire logic full_duplex,
    input wire logic tx_enable,
    input wire logic rx_preamble,
    input wire logic rx_dest_valid,
    // Pause handshake and back pressure
    input wire logic pause_req,
    input wire logic pause_zero_time,
    input wire logic pause_sent,
    input wire logic jam
);
    // Longest legal jam: top code on a slow link
    localparam int JAM_MAX = 12 * JAM_STEP_CYCLES + JAM_EXTRA_CYCLES;
    localparam int JAM_MIN = JAM_UNIT_CYCLES - 1;
    logic [31:0] jam_len; // Cycles of the current jam so far
    // Counts jam cycles, cleared while idle
    always_ff @(posedge aclk) begin
        if (!aresetn || !jam) begin
            jam_len <= 32'h0;
        end else begin
            jam_len <= jam_len + 32'h1;
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_pause_tx; pause_req |-> tx_enable; endproperty
    a_pause_tx: assert property (p_pause_tx)
        else $error("pause with tx off");
    property p_jam_tx; !tx_enable |=> !jam; endproperty
    a_jam_tx: assert property (p_jam_tx)
        else $error("jam with tx off");
    property p_jam_fd; full_duplex |=> !jam; endproperty
    a_jam_fd: assert property (p_jam_fd)
        else $error("jam in full duplex");
    property p_pause_hd; !full_duplex |=> !pause_req; endproperty
    a_pause_hd: assert property (p_pause_hd)
        else $error("pause in half duplex");
    property p_jam_cause;
        $rose(jam) |-> $past(rx_preamble) || $past(rx_dest_valid);
    endproperty
    a_jam_cause: assert property (p_jam_cause)
        else $error("jam without frame");
    property p_pause_hold;
        pause_req && !pause_sent && full_duplex ##1 tx_enable && full_duplex
        |-> pause_req && $stable(pause_zero_time);
    endproperty
    a_pause_hold: assert property (p_pause_hold)
        else $error("pending pause lost");
    property p_pause_done; pause_req && pause_sent |=> !pause_req; endproperty
    a_pause_done: assert property (p_pause_done)
        else $error("pause kept after sent");
    property p_zero_req;
        pause_zero_time |-> pause_req || !tx_enable;
    endproperty
    a_zero_req: assert property (p_zero_req)
        else $error("zero time without request");
    property p_jam_max; jam |-> jam_len < JAM_MAX; endproperty
    a_jam_max: assert property (p_jam_max)
        else $error("jam too long");
    property p_jam_min;
        $fell(jam) && $past(tx_enable) && !$past(full_duplex)
        |-> $past(jam_len) >= JAM_MIN;
    endproperty
    a_jam_min: assert property (p_jam_min)
        else $error("jam too short");
endmodule
bind flow_trigger flow_trigger_checker #(
    .JAM_UNIT_CYCLES (JAM_UNIT_CYCLES),
    .JAM_STEP_CYCLES (JAM_STEP_CYCLES),
    .JAM_EXTRA_CYCLES(JAM_EXTRA_CYCLES)
) flow_trigger_checker_inst (
    .aclk, .aresetn, .full_duplex, .tx_enable, .rx_preamble, .rx_dest_valid,
    .pause_req, .pause_zero_time, .pause_sent, .jam
);

// ### tb/mac_model.sv
// Transmit side of the MAC: sends a pending pause after a delay
`timescale 1ns/1ps
module mac_model (
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Pause handshake
    input  wire logic       pause_req,
    output logic            pause_sent,
    // Cycles until a transmit window opens
    input  wire logic [7:0] gap
);
    logic [7:0] wait_cnt; // Cycles the pause has waited
    // Holds the pause until the window, then one sent pulse
    always_ff @(posedge aclk) begin
        if (!aresetn || !pause_req || pause_sent) begin
            wait_cnt   <= 8'h00;
            pause_sent <= 1'b0;
        end else begin
            wait_cnt   <= wait_cnt + 8'h01;
            pause_sent <= (wait_cnt >= gap);
        end
    end
endmodule

// ### tb/tb_flow_trigger.sv
// Self-checking bench for the flow control trigger
`timescale 1ns/1ps
`include "flow_trigger_defines.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
    failures++; $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); \
    end end
module tb_flow_trigger;
    localparam int UNIT = 4;  // Shortened jam base
    localparam int STEP = 20; // Shortened long step
    localparam int EXTRA = 2; // Shortened slow-link surplus
    localparam logic [7:0] CFG_A = `FLOW_CFG_OFFSET;
    localparam logic [7:0] STAT_A = `FLOW_STAT_OFFSET;
    // Bus and link signals
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, full_duplex, link_100, jam;
    logic tx_enable, rx_preamble, rx_dest_valid, rx_dest_multicast;
    logic rx_dest_broadcast, rx_dest_match, pause_req, pause_zero_time;
    logic pause_sent;
    logic [7:0] awaddr, araddr, gap;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic [15:0] rx_fifo_level;
    int failures, check_count, n;
    flow_trigger #(.JAM_UNIT_CYCLES(UNIT), .JAM_STEP_CYCLES(STEP),
        .JAM_EXTRA_CYCLES(EXTRA)) flow_trigger_inst (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .rx_fifo_level,
        .full_duplex, .link_100, .tx_enable, .rx_preamble, .rx_dest_valid,
        .rx_dest_multicast, .rx_dest_broadcast, .rx_dest_match, .pause_req,
        .pause_zero_time, .pause_sent, .jam);
    mac_model mac_model_inst (.aclk, .aresetn, .pause_req, .pause_sent,
        .gap);
    // Clock at 200 MHz
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        conclude();
    end
    // Prints the counts and the verdict
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Configuration word from its fields
    function automatic logic [31:0] cfg(input logic [7:0] hi, lo,
        input logic [3:0] code, input logic [2:0] sel, input logic any);
        return {8'h00, hi, lo, code, sel, any};
    endfunction
    // Jam length in cycles for a code and link speed
    function automatic int exp_len(input logic [3:0] code, input logic slow);
        int base [4] = '{1, 2, 3, 5};
        return (code < 4 ? base[code[1:0]] * UNIT : (code - 3) * STEP)
            + (slow ? EXTRA : 0);
    endfunction
    // Bus write: address and data together, wait for the response
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
        input logic [3:0] s, output logic [1:0] resp);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask
    // Bus read
    task automatic rd(input logic [7:0] a, output logic [31:0] v,
        output logic [1:0] resp);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        v = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    // One receive event, then the jam length that follows
    task automatic fire(input logic pre, input logic [2:0] kind,
        input logic fast, output int len);
        @(posedge aclk);
        rx_preamble <= pre;
        rx_dest_valid <= !pre;
        {rx_dest_multicast, rx_dest_broadcast, rx_dest_match} <= kind;
        link_100 <= fast;
        @(posedge aclk);
        rx_preamble <= 1'b0;
        rx_dest_valid <= 1'b0;
        link_100 <= !fast;
        len = 0;
        for (int i = 0; i < 400; i++) begin
            @(posedge aclk);
            if (jam !== 1'b1) break;
            len++;
        end
    endtask
    // Waits for the partner to take the pending pause
    task automatic wait_sent();
        for (int i = 0; i < 64; i++) begin
            @(posedge aclk);
            if (pause_req === 1'b1 && pause_sent === 1'b1) break;
        end
    endtask
    // Main sequence
    initial begin
        failures = 0;
        check_count = 0;
        void'($urandom(32'h712a0def));
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {full_duplex, rx_preamble, rx_dest_valid, rx_dest_multicast} = '0;
        {rx_dest_broadcast, rx_dest_match, awaddr, araddr, wdata} = '0;
        {tx_enable, link_100, wstrb, rx_fifo_level, gap} = '1;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rx_fifo_level <= 16'd63;
        rd(CFG_A, d, r);
        `CHK({r, d}, {`RESP_OKAY, `CFG_RESET})
        rd(8'h10, d, r);
        `CHK({r, d}, {`RESP_SLVERR, 32'h0})
        wr(8'h10, 32'hffffffff, 4'hf, r);
        `CHK(r, `RESP_SLVERR)
        wr(CFG_A, 32'hffffffff, 4'hf, r);
        wr(CFG_A, 32'h0, 4'b0100, r);
        rd(CFG_A, d, r);
        `CHK(d, `CFG_WMASK & 32'hff00ffff)
        $display("test registers done");
        wr(CFG_A, cfg(8'h01, 8'h00, 4'h0, 3'h0, 1'b1), 4'hf, r);
        fire(1'b1, 3'h0, 1'b1, n);
        `CHK(n, 0)
        rx_fifo_level <= 16'd64;
        for (int c = 0; c < 16; c++) begin
            d[0] = 1'($urandom);
            wr(CFG_A, cfg(8'h01, 8'h00, 4'(c), 3'($urandom), 1'b1), 4'hf, r);
            fire(1'b1, 3'($urandom), d[0], n);
            `CHK(n, exp_len(4'(c), !d[0]))
        end
        wr(CFG_A, cfg(8'h01, 8'h00, 4'h0, 3'h7, 1'b1), 4'hf, r);
        fire(1'b0, 3'h7, 1'b1, n);
        `CHK(n, 0)
        $display("test any-frame jam done");
        for (int b = 0; b < 3; b++) begin
            wr(CFG_A, cfg(8'h01, 8'h00, 4'h0, 3'h1 << b, 1'b0), 4'hf, r);
            fire(1'b0, 3'h1 << b, 1'b1, n);
            `CHK(n, UNIT)
            fire(1'b0, ~(3'h1 << b), 1'b1, n);
            `CHK(n, 0)
        end
        tx_enable <= 1'b0;
        fire(1'b0, 3'h4, 1'b1, n);
        `CHK(n, 0)
        tx_enable <= 1'b1;
        full_duplex <= 1'b1;
        fire(1'b0, 3'h4, 1'b1, n);
        `CHK(n, 0)
        $display("test selected jam done");
        gap <= 8'($urandom_range(6, 0));
        rx_fifo_level <= 16'd0;
        wr(CFG_A, cfg(8'h02, 8'h01, 4'h0, 3'h0, 1'b1), 4'hf, r);
        rx_fifo_level <= 16'd128;
        repeat (2) @(posedge aclk);
        `CHK({pause_req, pause_zero_time}, 2'b10)
        tx_enable <= 1'b0;
        @(posedge aclk);
        `CHK(pause_req, 1'b0)
        tx_enable <= 1'b1;
        wait_sent();
        rd(STAT_A, d, r);
        `CHK(d, (32'h1 << `STAT_PAUSED_BIT) | (32'h1 << `STAT_HIGH_BIT))
        rx_fifo_level <= 16'd63;
        repeat (2) @(posedge aclk);
        `CHK({pause_req, pause_zero_time}, 2'b11)
        wait_sent();
        @(posedge aclk);
        `CHK({pause_req, pause_zero_time}, 2'b00)
        $display("test pause done");
        wr(CFG_A, cfg(8'h02, 8'h01, 4'h0, 3'h7, 1'b0), 4'hf, r);
        rx_fifo_level <= 16'd128;
        repeat (4) @(posedge aclk);
        `CHK(pause_req, 1'b0)
        rd(STAT_A, d, r);
        `CHK(d, 32'h1 << `STAT_HIGH_BIT)
        $display("test pause gating done");
        conclude();
    end
endmodule
